// ### core/addr_tenure_master.sv
`timescale 1ns/1ps
// Behaviour
// - Hold request until qualified grant arrives
// - Qualified: grant, bus idle, retry negated twice
// - Qualified grant starts busy, start, address
// - Arbiter grants one address master only
// - Single master may tie grant asserted
// - Parked grant skips request, saves cycles
// - Busy negated one cycle after acknowledge
// - Unused grant allowed after cancelled atomic
// - Start asserted together with address busy
// - Snooped start may lag address busy
// - Acknowledge comes at least one cycle later
// - At most two own transactions pipelined
// - Arbiter controls pipeline depth and sync
// - Data tenures follow address tenure order
// - Extended start only for direct-store
// - Drive odd parity per address byte
// - Check snooped address parity, flag mismatch
// - Config bit picks machine check or checkstop
module addr_tenure_master
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Transaction request from the core
  input wire logic req_valid_i,
  input wire logic req_cancel_i,
  input wire logic [addr_tenure_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [addr_tenure_pkg::ATTR_W-1:0] req_attr_i,
  input wire addr_tenure_pkg::xfer_kind_t req_kind_i,
  input wire logic req_global_i,
  output logic req_ready_o,
  // Data tenure sequencing
  input wire logic data_done_i,
  output logic data_go_o,
  // Snoop and parity configuration
  input wire logic snoop_hit_type_i,
  input wire logic par_check_en_i,
  input wire logic machine_check_enable_i,
  output logic retried_o,
  output addr_tenure_pkg::par_action_t par_action_o,
  // Bus side
  addr_bus_if.master bus
);
  import addr_tenure_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_REQ,
    ST_ADDR,
    ST_GAP
  } state_t;

  state_t state_q;
  logic retry_prev_q;
  logic retry_now;
  logic qual_grant;
  logic start;
  logic acked;
  logic [1:0] pipe_q;
  logic pipe_full;
  logic [ADDR_W-1:0] addr_q;
  logic [ATTR_W-1:0] attr_q;
  logic global_q;
  xfer_kind_t kind_q;
  logic snoop_start_pend_q;
  logic par_err_q;
  par_action_t par_action_q;
  logic retried_q;

  ////////////////////////////////////////////////////////////////////////
  // Arbitration
  assign retry_now = ~bus.addr_retry_n;
  assign qual_grant = ~bus.bus_grant_n & bus.addr_busy_n & ~retry_now & ~retry_prev_q;
  assign pipe_full = (pipe_q >= 2'(MAX_PIPE));
  // Parked case: a standing grant qualifies straight from idle
  assign start = req_valid_i & ~req_cancel_i & ~pipe_full & qual_grant
               & (state_q == ST_IDLE || state_q == ST_REQ);
  assign acked = (state_q == ST_ADDR) & ~bus.addr_ack_n;
  assign req_ready_o = start;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      retry_prev_q <= 1'b0;
    end else begin
      retry_prev_q <= retry_now;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_ADDR;
          end else if (req_valid_i & ~req_cancel_i & ~pipe_full) begin
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          // Cancelled atomic: request was up at least this one cycle, bus unused
          if (start) begin
            state_q <= ST_ADDR;
          end else if (req_cancel_i | ~req_valid_i) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (acked) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.bus_request_n = ~(state_q == ST_REQ);

  ////////////////////////////////////////////////////////////////////////
  // Address transfer
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      addr_q <= '0;
      attr_q <= '0;
      global_q <= 1'b0;
      kind_q <= KIND_MEM;
    end else if (start) begin
      addr_q <= req_addr_i;
      attr_q <= req_attr_i;
      global_q <= req_global_i;
      kind_q <= req_kind_i;
    end
  end

  // Busy and start share one state, so start can never lag busy
  assign bus.addr_busy_n_oe = (state_q == ST_ADDR);
  assign bus.addr_busy_n_o = ~(state_q == ST_ADDR);
  assign bus.addr_oe = (state_q == ST_ADDR);
  assign bus.addr_o = addr_q;
  assign bus.attr_o = attr_q;
  assign bus.coherent_global_n_o = ~global_q;
  assign bus.xfer_start_n_oe = (state_q == ST_ADDR);
  assign bus.ext_xfer_start_n_oe = (state_q == ST_ADDR);
  // Start pulses only in the first address cycle
  logic first_q;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      first_q <= 1'b0;
    end else begin
      first_q <= start;
    end
  end
  assign bus.xfer_start_n_o = ~(first_q & (kind_q == KIND_MEM));
  assign bus.ext_xfer_start_n_o = ~(first_q & (kind_q == KIND_DIRECT));
  assign bus.addr_parity_o = odd_parity(addr_q);

  ////////////////////////////////////////////////////////////////////////
  // Pipeline depth and data ordering
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pipe_q <= PIPE_RST;
    end else if (acked & ~data_done_i) begin
      pipe_q <= pipe_q + 2'h1;
    end else if (~acked & data_done_i & (pipe_q != 2'h0)) begin
      pipe_q <= pipe_q - 2'h1;
    end
  end

  // Data tenures are granted oldest first; the write-only grant may bypass
  assign data_go_o = (pipe_q != 2'h0) & (~bus.data_grant_n | ~bus.write_only_data_grant_n);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      retried_q <= 1'b0;
    end else begin
      retried_q <= (state_q == ST_ADDR) & retry_now;
    end
  end
  assign retried_o = retried_q;

  ////////////////////////////////////////////////////////////////////////
  // Snoop parity check
  // A start seen while another master owns the bus may trail its busy
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      snoop_start_pend_q <= 1'b0;
      par_err_q <= 1'b0;
      par_action_q <= ERR_NONE;
    end else begin
      snoop_start_pend_q <= 1'b0;
      par_err_q <= 1'b0;
      par_action_q <= ERR_NONE;
      if (state_q != ST_ADDR && ~bus.xfer_start_n && ~bus.coherent_global_n && snoop_hit_type_i) begin
        if (odd_parity(bus.addr) != bus.addr_parity) begin
          par_err_q <= 1'b1;
          if (par_check_en_i) begin
            par_action_q <= machine_check_enable_i ? ERR_MACHINE_CHECK : ERR_CHECKSTOP;
          end
        end
      end
    end
  end
  assign bus.addr_par_err_n = ~par_err_q;
  assign par_action_o = par_action_q;
endmodule // addr_tenure_master

// ### core/addr_tenure_pkg.sv
package addr_tenure_pkg;
  localparam int ADDR_W = 32;
  localparam int ATTR_W = 16;
  localparam int PAR_W = 4;
  // Minimum cycles of address busy negated after an acknowledge
  localparam int ABB_GAP_CYC = 1;
  // Minimum cycles a request is held when a grant goes unused
  localparam int REQ_HOLD_CYC = 1;
  // Own transactions allowed on the bus at once
  localparam int MAX_PIPE = 2;
  localparam logic [1:0] PIPE_RST = 2'h0;

  typedef enum logic [0:0] {
    KIND_MEM,
    KIND_DIRECT
  } xfer_kind_t;

  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_MACHINE_CHECK,
    ERR_CHECKSTOP
  } par_action_t;

  function automatic logic [PAR_W-1:0] odd_parity(input logic [ADDR_W-1:0] a);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ~(^a[8*i +: 8]);
    end
    return p;
  endfunction
endpackage

// ### core/addr_bus_if.sv
`timescale 1ns/1ps
interface addr_bus_if;
  import addr_tenure_pkg::*;
  logic bus_request_n;
  logic bus_grant_n;
  logic addr_busy_n_o;
  logic addr_busy_n_oe;
  logic addr_busy_n;
  logic addr_retry_n;
  logic addr_ack_n;
  logic data_grant_n;
  logic write_only_data_grant_n;
  logic xfer_start_n_o;
  logic xfer_start_n_oe;
  logic xfer_start_n;
  logic ext_xfer_start_n_o;
  logic ext_xfer_start_n_oe;
  logic ext_xfer_start_n;
  logic coherent_global_n_o;
  logic coherent_global_n;
  logic [ADDR_W-1:0] addr_o;
  logic [ADDR_W-1:0] addr;
  logic [ATTR_W-1:0] attr_o;
  logic [ATTR_W-1:0] attr;
  logic addr_oe;
  logic [PAR_W-1:0] addr_parity_o;
  logic [PAR_W-1:0] addr_parity_drv;
  logic [PAR_W-1:0] addr_parity;
  logic addr_par_err_n;

  // Wired-or style resolution: undriven shared lines read negated
  assign addr_busy_n = addr_busy_n_oe ? addr_busy_n_o : 1'b1;
  assign xfer_start_n = xfer_start_n_oe ? xfer_start_n_o : 1'b1;
  assign ext_xfer_start_n = ext_xfer_start_n_oe ? ext_xfer_start_n_o : 1'b1;
  assign coherent_global_n = addr_oe ? coherent_global_n_o : 1'b1;
  assign addr = addr_oe ? addr_o : '0;
  assign attr = addr_oe ? attr_o : '0;
  assign addr_parity = addr_oe ? addr_parity_o : addr_parity_drv;

  modport master (
    output bus_request_n, addr_busy_n_o, addr_busy_n_oe, xfer_start_n_o, xfer_start_n_oe,
    output ext_xfer_start_n_o, ext_xfer_start_n_oe, coherent_global_n_o, addr_o, attr_o, addr_oe,
    output addr_parity_o, addr_par_err_n,
    input bus_grant_n, addr_busy_n, addr_retry_n, addr_ack_n, data_grant_n, write_only_data_grant_n,
    input xfer_start_n, ext_xfer_start_n, coherent_global_n, addr, addr_parity
  );
  modport system (
    output bus_grant_n, addr_retry_n, addr_ack_n, data_grant_n, write_only_data_grant_n,
    output addr_parity_drv,
    input bus_request_n, addr_busy_n, xfer_start_n, ext_xfer_start_n, coherent_global_n,
    input addr, attr, addr_parity, addr_par_err_n
  );
endinterface

// ### core/addr_tenure_system.sv
`timescale 1ns/1ps
module addr_tenure_system
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Arbiter policy
  input wire logic park_i,
  input wire logic [1:0] ack_delay_i,
  input wire logic retry_i,
  input wire logic data_grant_i,
  input wire logic write_only_grant_i,
  input wire logic [addr_tenure_pkg::PAR_W-1:0] snoop_parity_i,
  // Observed tenure
  output logic tenure_o,
  output logic [addr_tenure_pkg::ADDR_W-1:0] seen_addr_o,
  output logic par_err_seen_o,
  // Bus side
  addr_bus_if.system bus
);
  import addr_tenure_pkg::*;

  logic grant_q;
  logic in_tenure_q;
  logic [1:0] wait_q;
  logic [ADDR_W-1:0] seen_q;
  logic ack_q;

  ////////////////////////////////////////////////////////////////////////
  // Grant: one master only; parked grant may stand with no request
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= (park_i | ~bus.bus_request_n) & bus.addr_busy_n & ~in_tenure_q;
    end
  end
  assign bus.bus_grant_n = ~grant_q;

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge no sooner than the cycle after start
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      in_tenure_q <= 1'b0;
      wait_q <= 2'h0;
      ack_q <= 1'b0;
      seen_q <= '0;
    end else begin
      ack_q <= 1'b0;
      if (~bus.xfer_start_n | ~bus.ext_xfer_start_n) begin
        // Zero delay answers in the very next cycle, the earliest allowed
        in_tenure_q <= (ack_delay_i != 2'h0);
        ack_q <= (ack_delay_i == 2'h0);
        wait_q <= ack_delay_i - 2'h1;
        seen_q <= bus.addr;
      end else if (in_tenure_q && !ack_q) begin
        if (wait_q == 2'h0) begin
          ack_q <= 1'b1;
          in_tenure_q <= 1'b0;
        end else begin
          wait_q <= wait_q - 2'h1;
        end
      end
    end
  end
  assign bus.addr_ack_n = ~ack_q;
  assign bus.addr_retry_n = ~retry_i;
  assign bus.data_grant_n = ~data_grant_i;
  assign bus.write_only_data_grant_n = ~write_only_grant_i;
  assign bus.addr_parity_drv = snoop_parity_i;
  assign tenure_o = in_tenure_q;
  assign seen_addr_o = seen_q;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      par_err_seen_o <= 1'b0;
    end else begin
      par_err_seen_o <= ~bus.addr_par_err_n;
    end
  end
endmodule // addr_tenure_system

// ### verif/addr_tenure_properties.sv
`timescale 1ns/1ps
module addr_tenure_properties
  import addr_tenure_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Watched bus lines
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic addr_busy_n,
  input wire logic addr_retry_n,
  input wire logic addr_ack_n,
  input wire logic xfer_start_n,
  input wire logic ext_xfer_start_n,
  input wire logic addr_oe,
  input wire logic [addr_tenure_pkg::ADDR_W-1:0] addr,
  input wire logic [addr_tenure_pkg::PAR_W-1:0] addr_parity
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////
  start_with_busy_a: assert property (!xfer_start_n || !ext_xfer_start_n |-> !addr_busy_n)
    else $error("start seen without address busy");
  busy_opens_start_a: assert property ($fell(addr_busy_n) |-> !xfer_start_n || !ext_xfer_start_n)
    else $error("address busy taken without a start");
  qualified_grant_a: assert property ($fell(addr_busy_n) |-> !$past(bus_grant_n) && $past(addr_busy_n)
    && $past(addr_retry_n) && $past(addr_retry_n, 2)) else $error("busy taken without a qualified grant");
  request_drop_a: assert property ($fell(addr_busy_n) |-> bus_request_n)
    else $error("request still asserted while busy");
  busy_gap_a: assert property (!addr_ack_n && !addr_busy_n |=> addr_busy_n)
    else $error("busy not released after acknowledge");
  addr_parity_a: assert property (addr_oe |-> ^{addr[7:0], addr_parity[0]} && ^{addr[15:8], addr_parity[1]}
    && ^{addr[23:16], addr_parity[2]} && ^{addr[31:24], addr_parity[3]}) else $error("address parity not odd");
  ack_not_early_a: assert property (!xfer_start_n |-> addr_ack_n)
    else $error("acknowledge together with start");
  ack_bound_a: assert property (!xfer_start_n |-> ##[1:4] !addr_ack_n)
    else $error("acknowledge missing after start");
endmodule // addr_tenure_properties

// ### verif/address_tenure_master_tb.sv
`timescale 1ns/1ps
module address_tenure_master_tb;
  import addr_tenure_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_cancel = 1'b0, data_done = 1'b0, data_grant = 1'b0;
  logic park = 1'b0, retry = 1'b0, req_ready, data_go, retried, tenure, par_err_seen;
  logic [1:0] ack_delay = 2'h0;
  logic [31:0] req_addr = 32'h0, seen_addr;
  xfer_kind_t req_kind = KIND_MEM;
  par_action_t par_action;
  int n_errors = 0, check_count = 0, cycles = 0;
  addr_bus_if addr_bus_if_i();
  addr_tenure_master addr_tenure_master_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .req_valid_i(req_valid),
    .req_cancel_i(req_cancel), .req_addr_i(req_addr), .req_attr_i(req_addr[15:0]), .req_kind_i(req_kind),
    .req_global_i(1'b1), .req_ready_o(req_ready), .data_done_i(data_done), .data_go_o(data_go),
    .snoop_hit_type_i(1'b1), .par_check_en_i(1'b1), .machine_check_enable_i(park), .retried_o(retried),
    .par_action_o(par_action), .bus(addr_bus_if_i.master));
  addr_tenure_system addr_tenure_system_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .park_i(park),
    .ack_delay_i(ack_delay), .retry_i(retry), .data_grant_i(data_grant), .write_only_grant_i(1'b0),
    .snoop_parity_i(4'h0), .tenure_o(tenure), .seen_addr_o(seen_addr), .par_err_seen_o(par_err_seen),
    .bus(addr_bus_if_i.system));
  addr_tenure_properties addr_tenure_properties_i (.sys_clk_i(sys_clk), .nrst_i(nrst),
    .bus_request_n(addr_bus_if_i.bus_request_n), .bus_grant_n(addr_bus_if_i.bus_grant_n),
    .addr_busy_n(addr_bus_if_i.addr_busy_n), .addr_retry_n(addr_bus_if_i.addr_retry_n),
    .addr_ack_n(addr_bus_if_i.addr_ack_n), .xfer_start_n(addr_bus_if_i.xfer_start_n),
    .ext_xfer_start_n(addr_bus_if_i.ext_xfer_start_n), .addr_oe(addr_bus_if_i.addr_oe),
    .addr(addr_bus_if_i.addr), .addr_parity(addr_bus_if_i.addr_parity));
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The run is short; a hang far past it means a lost handshake
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic txn(input logic [31:0] a, input xfer_kind_t k, input logic [1:0] d);
    int n;
    n = 0;
    ack_delay = d;
    req_addr = a;
    req_kind = k;
    req_valid = 1'b1;
    repeat (40) begin
      #1;
      if (req_ready === 1'b1) break;
      @(negedge sys_clk);
    end
    chk("ready", 1, req_ready);
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk("busy", 0, addr_bus_if_i.addr_busy_n);
    chk("request", 1, addr_bus_if_i.bus_request_n);
    chk("start", 0, k == KIND_MEM ? addr_bus_if_i.xfer_start_n : addr_bus_if_i.ext_xfer_start_n);
    chk("other start", 1, k == KIND_MEM ? addr_bus_if_i.ext_xfer_start_n : addr_bus_if_i.xfer_start_n);
    while (addr_bus_if_i.addr_ack_n !== 1'b0 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("ack cycles", d + 1, n);
    @(negedge sys_clk);
    chk("seen addr", a, seen_addr);
    chk("gap", 1, addr_bus_if_i.addr_busy_n);
    chk("tenure", 0, tenure);
  endtask
  // Unparked, every acknowledge delay, both kinds
  task automatic t_unparked();
    for (int d = 0; d < 4; d++) begin
      txn(32'h1357_9BD0 + d, d[0] ? KIND_DIRECT : KIND_MEM, d[1:0]);
      data_done = 1'b1;
      @(negedge sys_clk);
      data_done = 1'b0;
    end
  endtask
  // Two own tenures fill the pipe; a third waits on data completion
  task automatic t_pipe();
    park = 1'b1;
    txn(32'hFFFF_0001, KIND_MEM, 2'h0);
    txn(32'h8000_00FF, KIND_MEM, 2'h1);
    req_valid = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("third refused", 0, req_ready);
    chk("data go", 0, data_go);
    data_grant = 1'b1;
    #1 chk("data go", 1, data_go);
    data_done = 1'b1;
    @(negedge sys_clk);
    data_done = 1'b0;
    txn(32'h0F0F_F0F0, KIND_MEM, 2'h3);
    repeat (2) begin
      data_done = 1'b1;
      @(negedge sys_clk);
      data_done = 1'b0;
      @(negedge sys_clk);
    end
    data_grant = 1'b0;
  endtask
  // Retry held keeps the grant unqualified; a cancelled request leaves the bus unused
  task automatic t_retry_cancel();
    int busy_seen;
    busy_seen = 0;
    retry = 1'b1;
    req_valid = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("retry blocks", 0, req_ready);
    chk("retried", 0, retried);
    retry = 1'b0;
    txn(32'h2468_ACE0, KIND_MEM, 2'h0);
    park = 1'b0;
    data_done = 1'b1;
    @(negedge sys_clk);
    data_done = 1'b0;
    req_valid = 1'b1;
    repeat (2) @(negedge sys_clk);
    // Grant arrives for a request that the core then withdraws
    chk("granted", 0, addr_bus_if_i.bus_grant_n);
    chk("request held", 0, addr_bus_if_i.bus_request_n);
    req_cancel = 1'b1;
    req_valid = 1'b0;
    repeat (6) begin
      @(negedge sys_clk);
      if (addr_bus_if_i.addr_busy_n !== 1'b1) busy_seen++;
    end
    req_cancel = 1'b0;
    chk("unused grant", 0, busy_seen);
    chk("request released", 1, addr_bus_if_i.bus_request_n);
    chk("no parity error", 0, par_err_seen);
    chk("no parity action", ERR_NONE, par_action);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    t_unparked();
    t_pipe();
    t_retry_cancel();
    test_done();
  end
endmodule // address_tenure_master_tb
